// ===== rpm_chk_asserts.sv
/* Port checker of the pattern matcher.
   Assumes it is bound onto rpm_top. */
`timescale 1ns/1ns
`default_nettype none
`include "rpm_map.svh"
module rpm_chk (
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_sfd,
  input wire logic        rx_valid,
  input wire logic        rx_end,
  input wire logic        match_event,
  input wire logic        match_seen
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Read completing this cycle
  logic rd;
  assign rd = penable && pready && !pwrite;
  a_ready_wait: assert property ($rose(penable) |-> !pready ##1 pready)
    else $error("late ready");
  a_ctrl_width: assert property (rd && paddr[15:2] == `RPM_IDX_CTRL |-> prdata[31:6] == 26'h0)
    else $error("offset too wide");
  a_mask_read: assert property (rd && paddr[15:4] == 12'h132 |-> prdata[31:16] == 16'h0 && !pslverr)
    else $error("bad mask read");
  a_pat_mapped: assert property (rd && paddr[15:2] inside {[14'h04a8:14'h04c7]} |-> !pslverr)
    else $error("pattern refused");
  a_evt_cause: assert property (match_event |-> $past(rx_valid) && !$past(rx_end))
    else $error("event without byte");
  a_evt_pulse: assert property (match_event |=> !match_event)
    else $error("long event");
  a_evt_seen: assert property (match_event |-> ##[1:2] match_seen)
    else $error("seen not set");
  a_frame_edge: assert property (rx_end || rx_sfd |=> !match_event)
    else $error("event at frame edge");
  c_match: cover property (match_event);
  c_refused: cover property (rd && pslverr);
  c_cleared: cover property ($fell(match_seen));
endmodule
bind rpm_top rpm_chk i_rpm_chk (.sys_clk, .reset_n, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .rx_sfd, .rx_valid, .rx_end, .match_event, .match_seen);
`default_nettype wire

// ===== rpm_link_partner.sv
/* Far end sending received frames.
   Assumes bytes are taken at rising sys_clk. */
`timescale 1ns/1ns
`default_nettype none
module rpm_link_partner (
  input  wire logic       sys_clk,
  input  wire logic       f_send,
  input  wire logic [7:0] f_len,
  input  wire logic [7:0] f_bad,
  input  wire logic       f_slow,
  output logic            rx_sfd,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_end,
  output logic            f_busy
);
  // Byte i is i xor 5a, bit 0 flipped at f_bad; idle data toggles so no stale byte looks valid
  initial
  begin
    {rx_sfd, rx_valid, rx_end, f_busy, rx_data} = 12'h0;
    forever
    begin
      @(posedge sys_clk);
      {rx_sfd, rx_valid, rx_end, f_busy, rx_data} <= {f_send, 2'b00, f_send, ~rx_data};
      if (f_send)
      begin
        for (int i = 0; i < f_len; i++)
        begin
          if (f_slow)
          begin
            @(posedge sys_clk);
            {rx_sfd, rx_valid, rx_data} <= {2'b00, ~rx_data};
          end
          @(posedge sys_clk);
          {rx_sfd, rx_valid, rx_data} <= {2'b01, 8'(i) ^ 8'h5a ^ 8'(i == f_bad)};
        end
        @(posedge sys_clk);
        {rx_valid, rx_end, rx_data} <= {2'b01, ~rx_data};
      end
    end
  end
endmodule
`default_nettype wire

// ===== rpm_map.svh
/*
  Register map, field positions, reset values and counts of the receive
  pattern matcher. Assumes word-indexed registers; byte address = 4 * index.
*/
`ifndef RPM_MAP_SVH
`define RPM_MAP_SVH

// Register indices; byte address is four times the index
`define RPM_IDX_PAT_FIRST   14'h04a8
`define RPM_IDX_PAT_LAST    14'h04c7
`define RPM_IDX_MASK_0_15   14'h04c8
`define RPM_IDX_MASK_16_31  14'h04c9
`define RPM_IDX_MASK_32_47  14'h04ca
`define RPM_IDX_MASK_48_63  14'h04cb
`define RPM_IDX_CTRL        14'h04cc
`define RPM_IDX_STATUS      14'h04cd

// Field layout
`define RPM_START_MSB       5
`define RPM_START_RESET     6'h0c
`define RPM_MASK_RESET      16'h0000
`define RPM_PAT_RESET       16'h0000
`define RPM_STAT_MATCH_BIT  0

// Sizes
`define RPM_PAT_BYTES       7'h40
`define RPM_PAT_WORDS       32

`endif

// ===== rpm_pkg.sv
/*
  Types of the receive pattern matcher.
  Assumes rpm_map.svh for all constants.
*/
`default_nettype none
`include "rpm_map.svh"

package rpm_pkg;
  typedef logic [15:0] rpm_word_t;
  typedef logic [6:0]  rpm_cnt_t;

  typedef enum logic [1:0] {
    RPM_IDLE    = 2'b00,
    RPM_COMPARE = 2'b01,
    RPM_DONE    = 2'b10
  } rpm_state_e;

  typedef struct packed {
    rpm_word_t [`RPM_PAT_WORDS-1:0] pat;
    rpm_word_t [3:0]                mask;
    logic [`RPM_START_MSB:0]        start;
    rpm_state_e                     state;
    rpm_cnt_t                       cnt;
    logic                           fail;
    logic                           match_evt;
    logic                           match_seen;
    logic                           pready;
    logic                           pslverr;
    logic [31:0]                    prdata;
  } rpm_state_s;
endpackage

`default_nettype wire

// ===== rpm_top.sv
/*
  Receive pattern matcher: APB register file holding a 64-byte pattern,
  per-byte masks and a start offset, plus the frame byte comparator.
  Assumes frame bytes arrive synchronous to sys_clk with a delimiter pulse
  before the first byte and an end pulse after the last.
*/
// Function
// - Mask bit one excludes byte; zero compares
// - Second mask register covers bytes 16 to 31
// - Third mask register covers bytes 32 to 47
// - Fourth mask register covers bytes 48 to 63
// - Six-bit start offset counts bytes after delimiter
// - Offset default twelve skips both address fields
// - First mask register covers bytes 0 to 15
// - Two pattern bytes per register, odd high
`timescale 1ns/1ns
`default_nettype none
`include "rpm_map.svh"

module rpm_top (
  input  wire logic          sys_clk,
  input  wire logic          reset_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [15:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          rx_sfd,
  input  wire logic          rx_valid,
  input  wire logic [7:0]    rx_data,
  input  wire logic          rx_end,
  output logic               match_event,
  output logic               match_seen
);
  import rpm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Pattern byte n: odd byte in the upper half of its word
  function automatic logic [7:0] pat_byte(input rpm_word_t [`RPM_PAT_WORDS-1:0] p, input logic [5:0] n);
    pat_byte = n[0] ? p[n[5:1]][15:8] : p[n[5:1]][7:0];
  endfunction

  // Mask bit of byte n: word n/16, bit n%16
  function automatic logic mask_bit(input rpm_word_t [3:0] m, input logic [5:0] n);
    mask_bit = m[n[5:4]][n[3:0]];
  endfunction

  rpm_state_s s_q;
  rpm_state_s s_d;

  logic [13:0] idx;
  logic        acc;
  logic        mapped;
  logic [31:0] rdata;
  logic        is_pat;
  rpm_cnt_t    pos;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and read mux

  assign idx    = paddr[15:2];
  assign is_pat = (idx >= `RPM_IDX_PAT_FIRST) && (idx <= `RPM_IDX_PAT_LAST);
  assign acc    = psel && penable && s_q.pready;

  always_comb
  begin
    mapped = 1'b1;
    rdata  = 32'h0000_0000;
    if (is_pat)
    begin
      rdata[15:0] = s_q.pat[5'(idx - `RPM_IDX_PAT_FIRST)];
    end
    else
    begin
      case (idx)
        `RPM_IDX_MASK_0_15:  rdata[15:0] = s_q.mask[0];
        `RPM_IDX_MASK_16_31: rdata[15:0] = s_q.mask[1];
        `RPM_IDX_MASK_32_47: rdata[15:0] = s_q.mask[2];
        `RPM_IDX_MASK_48_63: rdata[15:0] = s_q.mask[3];
        `RPM_IDX_CTRL:       rdata[`RPM_START_MSB:0] = s_q.start; // Reserved bits read zero
        `RPM_IDX_STATUS:     rdata[`RPM_STAT_MATCH_BIT] = s_q.match_seen;
        default:             mapped = 1'b0;
      endcase
    end
  end

  // Position within the pattern of the current byte
  assign pos = 7'(s_q.cnt - {1'b0, s_q.start});

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb
  begin
    s_d           = s_q;
    s_d.match_evt = 1'b0;
    // One wait state keeps pready a flop output
    s_d.pready    = psel && penable && !s_q.pready;
    s_d.pslverr   = psel && penable && !s_q.pready && !mapped;
    if (psel && penable && !s_q.pready)
    begin
      s_d.prdata = rdata;
    end

    // Write takes effect only at the completing edge
    if (acc && pwrite && mapped)
    begin
      if (is_pat)
      begin
        s_d.pat[5'(idx - `RPM_IDX_PAT_FIRST)] = pwdata[15:0];
      end
      else
      begin
        case (idx)
          `RPM_IDX_MASK_0_15:  s_d.mask[0] = pwdata[15:0];
          `RPM_IDX_MASK_16_31: s_d.mask[1] = pwdata[15:0];
          `RPM_IDX_MASK_32_47: s_d.mask[2] = pwdata[15:0];
          `RPM_IDX_MASK_48_63: s_d.mask[3] = pwdata[15:0];
          `RPM_IDX_CTRL:       s_d.start   = pwdata[`RPM_START_MSB:0];
          `RPM_IDX_STATUS:
          begin
            if (pwdata[`RPM_STAT_MATCH_BIT])
            begin
              s_d.match_seen = 1'b0;
            end
          end
          default: s_d.start = s_q.start;
        endcase
      end
    end

    // Frame comparator
    case (s_q.state)
      RPM_IDLE:
      begin
        if (rx_sfd)
        begin
          s_d.state = RPM_COMPARE;
          s_d.cnt   = 7'h00;
          s_d.fail  = 1'b0;
        end
      end
      RPM_COMPARE:
      begin
        if (rx_sfd)
        begin
          // A fresh delimiter restarts the frame
          s_d.cnt  = 7'h00;
          s_d.fail = 1'b0;
        end
        else if (rx_end)
        begin
          // Short frame never reached the last pattern byte
          s_d.state = RPM_IDLE;
        end
        else if (rx_valid)
        begin
          s_d.cnt = 7'(s_q.cnt + 7'h01);
          if (s_q.cnt >= {1'b0, s_q.start})
          begin
            // Masked bytes are skipped, unmasked must agree
            if (!mask_bit(s_q.mask, pos[5:0]) && (rx_data != pat_byte(s_q.pat, pos[5:0])))
            begin
              s_d.fail = 1'b1;
            end
            if (pos == `RPM_PAT_BYTES - 7'h01)
            begin
              s_d.state = RPM_DONE;
              if (!s_q.fail && (mask_bit(s_q.mask, pos[5:0]) || (rx_data == pat_byte(s_q.pat, pos[5:0]))))
              begin
                s_d.match_evt = 1'b1;
              end
            end
          end
        end
      end
      RPM_DONE:
      begin
        // Wait out the rest of the frame
        if (rx_end)
        begin
          s_d.state = RPM_IDLE;
        end
        else if (rx_sfd)
        begin
          s_d.state = RPM_COMPARE;
          s_d.cnt   = 7'h00;
          s_d.fail  = 1'b0;
        end
      end
      default: s_d.state = RPM_IDLE;
    endcase

    // Sticky flag: a new match wins over a clear in the same cycle
    if (s_d.match_evt)
    begin
      s_d.match_seen = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q       <= '0;
      s_q.start <= `RPM_START_RESET;
      s_q.state <= RPM_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign prdata      = s_q.prdata;
  assign pready      = s_q.pready;
  assign pslverr     = s_q.pslverr;
  assign match_event = s_q.match_evt;
  assign match_seen  = s_q.match_seen;

endmodule

`default_nettype wire

// ===== rx_pattern_match_config_tb_top.sv
/* Self-checking bench of the pattern matcher.
   Assumes rpm_top, rpm_link_partner and rpm_chk. */
`timescale 1ns/1ns
`default_nettype none
`include "rpm_map.svh"
module rx_pattern_match_config_tb_top;
  logic        sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic        rx_sfd, rx_valid, rx_end, match_event, match_seen, f_send = 0, f_slow = 0, f_busy;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [7:0]  rx_data, f_len = '0, f_bad = '0;
  int          n_mismatch = 0, checks_done = 0, n_evt = 0, cyc = 0;
  rpm_top i_rpm_top (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_sfd, .rx_valid, .rx_data, .rx_end, .match_event, .match_seen);
  rpm_link_partner i_rpm_link_partner (.sys_clk, .f_send, .f_len, .f_bad, .f_slow, .rx_sfd, .rx_valid,
    .rx_data, .rx_end, .f_busy);
  always #5 sys_clk = ~sys_clk;
  // Event counter and cycle ceiling
  always @(posedge sys_clk)
  begin
    cyc++;
    n_evt += int'(match_event === 1'b1);
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_of_test;
    end
  end
  task automatic end_of_test;
    if (n_mismatch == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One transfer, request held until pready is sampled high
  task automatic apb(input logic w, input logic [13:0] idx, input logic [31:0] wd);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, idx, 2'b00, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(posedge sys_clk);
  endtask
  task automatic frame(input int n, b, e);
    n_evt = 0;
    {f_len, f_bad, f_send} <= {8'(n), 8'(b), 1'b1};
    @(posedge sys_clk);
    f_send <= 1'b0;
    @(posedge sys_clk);
    while (f_busy === 1'b1)
      @(posedge sys_clk);
    chk("events", 32'(e), 32'(n_evt));
    chk("seen", 32'(e), {31'h0, match_seen});
    apb(0, `RPM_IDX_STATUS, 0);
    chk("status", 32'(e), rd);
    apb(1, `RPM_IDX_STATUS, 32'h1);
    chk("seen cleared", 32'h0, {31'h0, match_seen});
  endtask
  task automatic t_regs;
    apb(0, `RPM_IDX_CTRL, 0);
    chk("offset reset", 32'hc, rd);
    apb(0, `RPM_IDX_MASK_0_15, 0);
    chk("mask reset", 32'h0, rd);
    apb(1, `RPM_IDX_MASK_48_63, 32'hffff_a5c3);
    apb(0, `RPM_IDX_MASK_48_63, 0);
    chk("mask", 32'ha5c3, rd);
    apb(1, `RPM_IDX_MASK_48_63, 0);
    apb(0, 14'h04ce, 0);
    chk("refused", 32'h1, {rd[30:0], err});
  endtask
  // Pattern so that frame byte s+j meets pattern byte j; upper offset bits written must not stick
  task automatic t_match(input int s, input logic slow);
    f_slow <= slow;
    for (int k = 0; k < 64; k += 2)
      apb(1, `RPM_IDX_PAT_FIRST + 14'(k / 2), {16'h0, 8'(s + k + 1) ^ 8'h5a, 8'(s + k) ^ 8'h5a});
    apb(0, `RPM_IDX_PAT_FIRST, 0);
    chk("pattern", {16'h0, 8'(s + 1) ^ 8'h5a, 8'(s) ^ 8'h5a}, rd);
    apb(1, `RPM_IDX_CTRL, 32'(s) | 32'hffc0);
    apb(0, `RPM_IDX_CTRL, 0);
    chk("offset", 32'(s), rd);
    frame(s + 64, s - 1, 1);
    frame(s + 63, 255, 0);
    frame(s + 64, s + 63, 0);
  endtask
  // One byte in each mask register: compared when clear, ignored when set
  task automatic t_masks;
    for (int r = 0; r < 4; r++)
    begin
      frame(76, 13 + 17 * r, 0);
      apb(1, `RPM_IDX_MASK_0_15 + 14'(r), 32'h1 << (r + 1));
      frame(76, 13 + 17 * r, 1);
      apb(1, `RPM_IDX_MASK_0_15 + 14'(r), 0);
    end
  endtask
  // Reset in mid-run must bring back the default offset and clear the pattern
  task automatic t_reset;
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    apb(0, `RPM_IDX_CTRL, 0);
    chk("offset after reset", 32'hc, rd);
    apb(0, `RPM_IDX_PAT_FIRST, 0);
    chk("pattern after reset", 32'h0, rd);
  endtask
  initial
  begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_regs;
    t_match(12, 0);
    t_masks;
    t_match(1, 1);
    t_match(0, 0);
    t_match(63, 0);
    t_reset;
    end_of_test;
  end
endmodule
`default_nettype wire
